// >>> rtl/gen_monitor_map.svh
// constants for the generator terminal monitor
`ifndef GEN_MONITOR_MAP_SVH
`define GEN_MONITOR_MAP_SVH
`define CLK_HZ           25000000
`define LAMP_SAMPLE_MS   500
`define FIELD_SAMPLE_MS  50
`define HALF_SEC_MS      500
`define TIMER_MAX        8'hFF
`define DUTY_FULL        8'h64
`define DUTY_STEP        8'h05
`define COEFF_RESET      8'h65
`define KEYON_TIME_RST   8'h05
`define LRUN_TIME_RST    8'h0F
`define FRUN_TIME_RST    8'h1E
`define FKEY_DUTY_RST    8'h41
`define FRUN_DUTY_RST    8'h05
`define FRUN_RPM_RST     14'h03E8
`define ADDR_CTRL        4'h0
`define ADDR_LKEY_TIME   4'h1
`define ADDR_LRUN_TIME   4'h2
`define ADDR_FKEY_TIME   4'h3
`define ADDR_FRUN_TIME   4'h4
`define ADDR_FKEY_DUTY   4'h5
`define ADDR_FRUN_DUTY   4'h6
`define ADDR_FRUN_RPM    4'h7
`define ADDR_COEFF       4'h8
`define ADDR_STATUS      4'h9
`define ADDR_FDUTY       4'hA
`define CTRL_FIELD_BIT   0
`define CTRL_PWM_BIT     1
`define CTRL_CLR_BIT     2
`endif

// >>> rtl/gen_monitor_pkg.sv
// types for the generator terminal monitor
package gen_monitor_pkg;
  typedef enum logic [1:0] {
    PHASE_CTRL_READY,
    PHASE_PT_READY,
    PHASE_CRANKING,
    PHASE_RUNNING
  } phase_t;
  typedef enum logic [1:0] {
    IGN_OFF,
    IGN_ACCESSORY,
    IGN_RUN,
    IGN_CRANK
  } ign_t;
endpackage

// >>> rtl/generator_terminal_monitor.sv
// generator lamp-line and field-line monitor with diagnostics
`timescale 1ns/1ps
`include "gen_monitor_map.svh"
// Operation
// - lamp timers count the lamp line once per second
// - lamp key-on test needs ready, no codes, 0 rpm
// - lamp high for key-on time sets fault
// - pwm output short persisting fails either test
// - lamp run test needs running, enabled, no codes
// - lamp low for run time sets fault
// - persistence timers clear when disabled or reset
// - fault clears when conditions gone, or on tool clear if timer below set time
// - sample averaged field duty every 50 ms
// - first-order lag filter on field duty
// - send duty on 5% change, once at 100%
// - field key-on test high duty for key-on time
// - field run test enable conditions
// - field duty low for run time sets fault
// - indicator on accessory, ready, or any fault
// - fault status equals lamp or field fault
// - filter coefficient eight-bit fraction of 256
// - field timers count half seconds up to 127.5 s
module generator_terminal_monitor #(
  parameter int CLK_HZ = `CLK_HZ
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        lamp_line,
  input  wire logic                        field_line,
  input  wire logic                        lamp_short_fault,
  input  wire gen_monitor_pkg::phase_t     phase,
  input  wire gen_monitor_pkg::ign_t       ignition,
  input  wire logic                        keyon_event,
  input  wire logic                        crank_cam_code,
  input  wire logic                        gen_disabled,
  input  wire logic                        rvc_app,
  input  wire logic [13:0]                 engine_rpm,
  input  wire logic                        tool_clear,
  input  wire logic [3:0]                  reg_addr,
  input  wire logic [15:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [15:0]                 reg_rdata,
  output logic                             lamp_fault,
  output logic                             field_fault,
  output logic                             indicator_status,
  output logic                             gen_fault_status,
  output logic      [7:0]                  filtered_field_duty,
  output logic                             duty_msg_send
);
  localparam int LAMP_TICKS  = CLK_HZ / 1000 * `LAMP_SAMPLE_MS;
  localparam int FIELD_TICKS = CLK_HZ / 1000 * `FIELD_SAMPLE_MS;
  localparam int HALF_PER_F  = `HALF_SEC_MS / `FIELD_SAMPLE_MS;
  if (FIELD_TICKS < 2 || LAMP_TICKS < FIELD_TICKS)
  begin
    $error("clock rate too low for sampling periods");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] lamp_sync_q;
  logic [1:0] field_sync_q;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      lamp_sync_q  <= 2'h0;
      field_sync_q <= 2'h0;
    end
    else
    begin
      lamp_sync_q  <= {lamp_sync_q[0], lamp_line};
      field_sync_q <= {field_sync_q[0], field_line};
    end
  wire lamp_s  = lamp_sync_q[1];
  wire field_s = field_sync_q[1];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [1:0]  ctrl_q;
  logic [7:0]  lkey_time_q, lrun_time_q, fkey_time_q, frun_time_q;
  logic [7:0]  fkey_duty_q, frun_duty_q, coeff_q;
  logic [13:0] frun_rpm_q;
  wire field_present = ctrl_q[`CTRL_FIELD_BIT];
  wire lamp_pwm      = ctrl_q[`CTRL_PWM_BIT];
  wire sw_clear      = reg_wr && reg_addr == `ADDR_CTRL
                       && reg_wdata[`CTRL_CLR_BIT];
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_q      <= 2'h1;
      lkey_time_q <= `KEYON_TIME_RST;
      lrun_time_q <= `LRUN_TIME_RST;
      fkey_time_q <= `KEYON_TIME_RST;
      frun_time_q <= `FRUN_TIME_RST;
      fkey_duty_q <= `FKEY_DUTY_RST;
      frun_duty_q <= `FRUN_DUTY_RST;
      frun_rpm_q  <= `FRUN_RPM_RST;
      coeff_q     <= `COEFF_RESET;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `ADDR_CTRL:      ctrl_q      <= reg_wdata[1:0];
        `ADDR_LKEY_TIME: lkey_time_q <= reg_wdata[7:0];
        `ADDR_LRUN_TIME: lrun_time_q <= reg_wdata[7:0];
        `ADDR_FKEY_TIME: fkey_time_q <= reg_wdata[7:0];
        `ADDR_FRUN_TIME: frun_time_q <= reg_wdata[7:0];
        `ADDR_FKEY_DUTY: fkey_duty_q <= reg_wdata[7:0];
        `ADDR_FRUN_DUTY: frun_duty_q <= reg_wdata[7:0];
        `ADDR_FRUN_RPM:  frun_rpm_q  <= reg_wdata[13:0];
        `ADDR_COEFF:     coeff_q     <= reg_wdata[7:0];
        default: ;
      endcase
    end

  // ----------------------------------------
  // tick generators
  // ----------------------------------------
  logic [31:0] ftick_cnt_q;
  logic [3:0]  half_cnt_q;
  logic [0:0]  lamp_div_q;
  wire ftick    = ftick_cnt_q == 32'(FIELD_TICKS - 1);
  wire half_sec = ftick && half_cnt_q == 4'(HALF_PER_F - 1);
  wire sec_tick = half_sec && lamp_div_q[0];
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      ftick_cnt_q <= 32'h0;
      half_cnt_q  <= 4'h0;
      lamp_div_q  <= 1'h0;
    end
    else
    begin
      ftick_cnt_q <= ftick ? 32'h0 : ftick_cnt_q + 32'h1;
      if (ftick)
        half_cnt_q <= half_sec ? 4'h0 : half_cnt_q + 4'h1;
      if (half_sec)
        lamp_div_q <= ~lamp_div_q;
    end

  // ----------------------------------------
  // field duty averaging and lag filter
  // ----------------------------------------
  logic [31:0] high_cnt_q;
  logic [15:0] filt_q;
  logic [7:0]  duty_sample;
  logic [63:0] duty_prod;
  assign duty_prod   = 64'(high_cnt_q) * 64'h64 + 64'(FIELD_TICKS / 2);
  assign duty_sample = 8'(duty_prod / 64'(FIELD_TICKS));
  wire [15:0] sample_fx = {duty_sample, 8'h00};
  wire signed [17:0] diff = $signed({2'b00, sample_fx})
                            - $signed({2'b00, filt_q});
  wire signed [25:0] step = diff * $signed({1'b0, coeff_q});
  wire [15:0] filt_d = 16'($signed({2'b00, filt_q}) + 18'(step >>> 8));
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      high_cnt_q <= 32'h0;
      filt_q     <= 16'h0;
    end
    else if (ftick)
    begin
      high_cnt_q <= 32'(field_s);
      filt_q     <= filt_d;
    end
    else
      high_cnt_q <= high_cnt_q + 32'(field_s);
  wire [7:0] filt_duty = 8'((filt_q + 16'h0080) >> 8);

  // ----------------------------------------
  // duty message trigger
  // ----------------------------------------
  logic [7:0] sent_q;
  logic       full_sent_q;
  logic       send_q;
  wire [7:0] delta = filt_duty > sent_q ? filt_duty - sent_q
                                        : sent_q - filt_duty;
  wire full_hit = filt_duty >= `DUTY_FULL && !full_sent_q;
  wire send_now = ftick && (delta >= `DUTY_STEP || full_hit);
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      sent_q      <= 8'h0;
      full_sent_q <= 1'b0;
      send_q      <= 1'b0;
    end
    else
    begin
      send_q <= send_now;
      if (send_now)
        sent_q <= filt_duty;
      if (ftick)
        full_sent_q <= filt_duty >= `DUTY_FULL;
    end

  // ----------------------------------------
  // enable conditions
  // ----------------------------------------
  wire keyon_ready = phase == gen_monitor_pkg::PHASE_PT_READY && keyon_event
                     && !crank_cam_code && engine_rpm == 14'h0;
  logic lamp_key_fault_q, lamp_run_fault_q;
  logic field_key_fault_q, field_run_fault_q;
  wire running  = phase == gen_monitor_pkg::PHASE_RUNNING;
  wire lrun_en  = !lamp_key_fault_q && running && !gen_disabled
                  && !crank_cam_code;
  wire fkey_en  = field_present && !rvc_app && keyon_ready;
  wire frun_en  = field_present && !field_key_fault_q && !gen_disabled
                  && running && engine_rpm < frun_rpm_q
                  && !lamp_fault && !crank_cam_code;
  wire lkey_cond = lamp_pwm ? lamp_short_fault : lamp_s;
  wire lrun_cond = lamp_pwm ? lamp_short_fault : !lamp_s;
  wire fkey_cond = filt_duty >= fkey_duty_q;
  wire frun_cond = filt_duty <= frun_duty_q;

  // ----------------------------------------
  // persistence timers
  // ----------------------------------------
  function automatic logic [7:0] persist(input logic [7:0] t,
                                         input logic en, input logic c,
                                         input logic tick);
    if (!en || !c)
      persist = 8'h0;
    else if (tick && t != `TIMER_MAX)
      persist = t + 8'h1;
    else
      persist = t;
  endfunction
  logic [7:0] lamp_high_persist_timer, lamp_low_persist_timer;
  logic [7:0] field_high_persist_timer, field_low_persist_timer;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      lamp_high_persist_timer  <= 8'h0;
      lamp_low_persist_timer   <= 8'h0;
      field_high_persist_timer <= 8'h0;
      field_low_persist_timer  <= 8'h0;
    end
    else
    begin
      lamp_high_persist_timer  <= persist(lamp_high_persist_timer,
                                  keyon_ready, lkey_cond, sec_tick);
      lamp_low_persist_timer   <= persist(lamp_low_persist_timer,
                                  lrun_en, lrun_cond, sec_tick);
      field_high_persist_timer <= persist(field_high_persist_timer,
                                  fkey_en, fkey_cond, half_sec);
      field_low_persist_timer  <= persist(field_low_persist_timer,
                                  frun_en, frun_cond, half_sec);
    end

  // ----------------------------------------
  // fault codes
  // ----------------------------------------
  wire clr = tool_clear || sw_clear;
  wire lkey_set = lamp_high_persist_timer >= lkey_time_q;
  wire lrun_set = lamp_low_persist_timer >= lrun_time_q;
  wire fkey_set = field_high_persist_timer >= {fkey_time_q[6:0], 1'b0};
  wire frun_set = field_low_persist_timer >= {frun_time_q[6:0], 1'b0};
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      lamp_key_fault_q  <= 1'b0;
      lamp_run_fault_q  <= 1'b0;
      field_key_fault_q <= 1'b0;
      field_run_fault_q <= 1'b0;
    end
    else
    begin
      lamp_key_fault_q  <= keyon_ready && lkey_cond && lkey_set
                           || lamp_key_fault_q && keyon_ready && lkey_cond
                           && !clr;
      lamp_run_fault_q  <= lrun_en && lrun_cond
                           && (lrun_set || lamp_run_fault_q && !clr);
      field_key_fault_q <= fkey_en && fkey_cond && fkey_set
                           || field_key_fault_q && fkey_en && fkey_cond
                           && !clr;
      field_run_fault_q <= frun_en && frun_cond
                           && (frun_set || field_run_fault_q && !clr);
    end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      lamp_fault          <= 1'b0;
      field_fault         <= 1'b0;
      indicator_status    <= 1'b0;
      gen_fault_status    <= 1'b0;
      filtered_field_duty <= 8'h0;
      duty_msg_send       <= 1'b0;
    end
    else
    begin
      lamp_fault          <= lamp_key_fault_q || lamp_run_fault_q;
      field_fault         <= field_key_fault_q || field_run_fault_q;
      gen_fault_status    <= lamp_fault || field_fault;
      indicator_status    <= ignition == gen_monitor_pkg::IGN_ACCESSORY
                             || phase == gen_monitor_pkg::PHASE_PT_READY
                             || lamp_fault || field_fault;
      filtered_field_duty <= filt_duty;
      duty_msg_send       <= send_q;
    end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0;
    unique case (reg_addr)
      `ADDR_CTRL:      rd_mux = {14'h0, ctrl_q};
      `ADDR_LKEY_TIME: rd_mux = {8'h0, lkey_time_q};
      `ADDR_LRUN_TIME: rd_mux = {8'h0, lrun_time_q};
      `ADDR_FKEY_TIME: rd_mux = {8'h0, fkey_time_q};
      `ADDR_FRUN_TIME: rd_mux = {8'h0, frun_time_q};
      `ADDR_FKEY_DUTY: rd_mux = {8'h0, fkey_duty_q};
      `ADDR_FRUN_DUTY: rd_mux = {8'h0, frun_duty_q};
      `ADDR_FRUN_RPM:  rd_mux = {2'h0, frun_rpm_q};
      `ADDR_COEFF:     rd_mux = {8'h0, coeff_q};
      `ADDR_STATUS:    rd_mux = {12'h0, field_run_fault_q,
                         field_key_fault_q, lamp_run_fault_q,
                         lamp_key_fault_q};
      `ADDR_FDUTY:     rd_mux = {8'h0, filt_duty};
      default:         rd_mux = 16'h0;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      reg_rdata <= 16'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 16'h0;
endmodule

// >>> verif/gen_monitor_props.sv
// port checker for the generator terminal monitor
`timescale 1ns/1ps
`include "gen_monitor_map.svh"
module gen_monitor_props #(
  parameter int CLK_HZ = `CLK_HZ
) (
  input wire logic                    mclk,
  input wire logic                    rst_n,
  input wire gen_monitor_pkg::phase_t phase,
  input wire gen_monitor_pkg::ign_t   ignition,
  input wire logic                    crank_cam_code,
  input wire logic                    gen_disabled,
  input wire logic                    rvc_app,
  input wire logic [13:0]             engine_rpm,
  input wire logic                    lamp_fault,
  input wire logic                    field_fault,
  input wire logic                    indicator_status,
  input wire logic                    gen_fault_status,
  input wire logic [7:0]              filtered_field_duty,
  input wire logic                    duty_msg_send
);
  // ----
  // checks
  // ----
  wire logic rdy;
  wire logic run;
  wire logic ind_cond;
  assign rdy = phase == gen_monitor_pkg::PHASE_PT_READY;
  assign run = phase == gen_monitor_pkg::PHASE_RUNNING;
  assign ind_cond = ignition == gen_monitor_pkg::IGN_ACCESSORY || rdy ||
                    lamp_fault || field_fault;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_fault_status_pair: assert property
    (gen_fault_status == $past(lamp_fault || field_fault))
    else $error("fault status does not follow faults");
  a_indicator_on: assert property
    (ind_cond |-> ##[1:2] indicator_status)
    else $error("indicator missing");
  a_indicator_off: assert property
    ((!ind_cond) [*3] |-> !indicator_status)
    else $error("indicator without cause");
  a_msg_single_pulse: assert property
    (duty_msg_send |=> !duty_msg_send)
    else $error("duty message pulse too long");
  a_duty_in_range: assert property
    (filtered_field_duty <= `DUTY_FULL)
    else $error("filtered duty above full scale");
  a_duty_tick_hold: assert property
    ($changed(filtered_field_duty) |=> $stable(filtered_field_duty) [*8])
    else $error("filtered duty changed between samples");
  a_lamp_set_gate: assert property
    ($rose(lamp_fault) |-> !crank_cam_code &&
      (run || (rdy && engine_rpm == 14'h0000)))
    else $error("lamp fault set while test disabled");
  a_field_set_gate: assert property
    ($rose(field_fault) |-> !crank_cam_code && ((rdy && !rvc_app) ||
      (run && !gen_disabled && engine_rpm < `FRUN_RPM_RST)))
    else $error("field fault set while test disabled");
endmodule
bind generator_terminal_monitor gen_monitor_props #(.CLK_HZ(CLK_HZ))
  gen_monitor_props_inst (.mclk(mclk), .rst_n(rst_n), .phase(phase),
  .ignition(ignition), .crank_cam_code(crank_cam_code),
  .gen_disabled(gen_disabled), .rvc_app(rvc_app), .engine_rpm(engine_rpm),
  .lamp_fault(lamp_fault), .field_fault(field_fault),
  .indicator_status(indicator_status), .gen_fault_status(gen_fault_status),
  .filtered_field_duty(filtered_field_duty), .duty_msg_send(duty_msg_send));

// >>> verif/regulator_model.sv
// regulator side model: lamp terminal level and field pwm
`timescale 1ns/1ps
module regulator_model (
  input  wire logic       mclk,
  input  wire logic       lamp_ok,
  input  wire logic [7:0] duty,
  output logic            lamp_line,
  output logic            field_line
);
  logic [6:0] cnt_q = 7'h00;
  always_ff @(posedge mclk)
  begin
    cnt_q <= (cnt_q == 7'h63) ? 7'h00 : cnt_q + 7'h01;
  end
  // low lamp level reports a regulator fault
  assign lamp_line  = lamp_ok;
  assign field_line = {1'b0, cnt_q} < duty;
endmodule

// >>> verif/tb.sv
// self-checking bench for the generator terminal monitor
`timescale 1ns/1ps
`include "gen_monitor_map.svh"
module tb;
  localparam gen_monitor_pkg::phase_t idle = gen_monitor_pkg::PHASE_CTRL_READY;
  localparam gen_monitor_pkg::phase_t ready = gen_monitor_pkg::PHASE_PT_READY;
  localparam gen_monitor_pkg::phase_t running = gen_monitor_pkg::PHASE_RUNNING;
  logic                    mclk, lamp_line, field_line, lamp_fault;
  logic                    field_fault, indicator_status, gen_fault_status;
  logic                    duty_msg_send;
  logic                    rst_n = 1'b0, lamp_ok = 1'b1, keyon_event = 1'b1;
  logic                    lamp_short_fault = 1'b0, crank_cam_code = 1'b0;
  logic                    gen_disabled = 1'b0, rvc_app = 1'b0;
  logic                    tool_clear = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]              reg_addr = 4'h0;
  logic [7:0]              duty = 8'h00, filtered_field_duty;
  logic [13:0]             engine_rpm = 14'h0000;
  logic [15:0]             reg_wdata = 16'h0000, reg_rdata;
  logic [15:0]             exp_q [$];
  logic [15:0]             rst_tab [12] = '{16'h0001, 16'h0005, 16'h000F,
    16'h0005, 16'h001E, 16'h0041, 16'h0005, 16'h03E8, 16'h0065, 16'h0000,
    16'h0000, 16'h0000};
  gen_monitor_pkg::phase_t phase = idle;
  gen_monitor_pkg::ign_t   ignition = gen_monitor_pkg::IGN_OFF;
  int                      n_errors = 0, cmp_count = 0;
  int                      n_msgs = 0;
  // ----
  // design and regulator
  // ----
  generator_terminal_monitor #(.CLK_HZ(2000)) generator_terminal_monitor_inst (
    .mclk(mclk), .rst_n(rst_n), .lamp_line(lamp_line),
    .field_line(field_line), .lamp_short_fault(lamp_short_fault),
    .phase(phase), .ignition(ignition), .keyon_event(keyon_event),
    .crank_cam_code(crank_cam_code), .gen_disabled(gen_disabled),
    .rvc_app(rvc_app), .engine_rpm(engine_rpm), .tool_clear(tool_clear),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lamp_fault(lamp_fault),
    .field_fault(field_fault), .indicator_status(indicator_status),
    .gen_fault_status(gen_fault_status),
    .filtered_field_duty(filtered_field_duty),
    .duty_msg_send(duty_msg_send));
  regulator_model regulator_model_inst (.mclk(mclk), .lamp_ok(lamp_ok),
    .duty(duty), .lamp_line(lamp_line), .field_line(field_line));
  // ----
  // tasks
  // ----
  task automatic final_report();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic chk_duty(input logic [7:0] e);
    rd(`ADDR_FDUTY, {8'h00, e});
    #1;
    cmp_count++;
    if (filtered_field_duty !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time,
               filtered_field_duty, e);
    end
  endtask
  function automatic logic [13:0] low_rpm();
    return 14'($urandom_range(999, 1));
  endfunction
  task automatic step(input gen_monitor_pkg::phase_t ph, input logic lo,
    input logic [7:0] dt, input logic [13:0] rp, input int n,
    input logic [15:0] e);
    @(posedge mclk);
    phase      <= ph;
    lamp_ok    <= lo;
    duty       <= dt;
    engine_rpm <= rp;
    ignition   <= gen_monitor_pkg::ign_t'($urandom_range(3));
    repeat (n) @(posedge mclk);
    rd(`ADDR_STATUS, e);
  endtask
  // ----
  // clock, watchdog, read monitor
  // ----
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    #3000000;
    n_errors++;
    final_report();
  end
  always @(posedge mclk)
  begin
    automatic logic seen = reg_rd;
    #1;
    if (seen === 1'b1)
    begin
      cmp_count++;
      if (reg_rdata !== exp_q[0])
      begin
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time,
                 reg_rdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  always @(posedge mclk)
    if (duty_msg_send === 1'b1)
      n_msgs++;
  // ----
  // scenarios
  // ----
  initial
  begin
    void'($urandom(50));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    wr(4'hF, 16'hFFFF);
    foreach (rst_tab[i]) rd(4'(i), rst_tab[i]);
    rd(4'hF, 16'h0000);
    for (int i = 1; i < 5; i++) wr(4'(i), 16'h0001);
    rd(`ADDR_FRUN_TIME, 16'h0001);
    crank_cam_code <= 1'b1;
    step(ready, 1'b1, 8'h00, 14'h0000, 4000, 16'h0000);
    crank_cam_code <= 1'b0;
    step(ready, 1'b1, 8'h00, 14'h0000, 500, 16'h0000);
    step(ready, 1'b1, 8'h00, 14'h0000, 5000, 16'h0001);
    tool_clear <= 1'b1;
    step(idle, 1'b1, 8'h00, 14'h0000, 1100, 16'h0000);
    tool_clear   <= 1'b0;
    gen_disabled <= 1'b1;
    step(running, 1'b0, 8'h32, low_rpm(), 4000, 16'h0000);
    gen_disabled <= 1'b0;
    step(running, 1'b0, 8'h32, low_rpm(), 6000, 16'h0002);
    step(running, 1'b1, 8'h32, low_rpm(), 1100, 16'h0000);
    wr(`ADDR_CTRL, 16'h0005);
    rd(`ADDR_CTRL, 16'h0001);
    step(running, 1'b1, 8'h02, 14'h03E8, 3000, 16'h0000);
    step(running, 1'b1, 8'h02, low_rpm(), 3000, 16'h0008);
    chk_duty(8'h02);
    rvc_app <= 1'b1;
    step(ready, 1'b0, 8'h50, 14'h0000, 3000, 16'h0000);
    rvc_app <= 1'b0;
    step(ready, 1'b0, 8'h50, 14'h0000, 3000, 16'h0004);
    chk_duty(8'h50);
    wr(`ADDR_CTRL, 16'h0003);
    lamp_short_fault <= 1'b1;
    step(ready, 1'b0, 8'h00, 14'h0000, 4000, 16'h0001);
    repeat (2) @(posedge mclk);
    cmp_count++;
    if (n_msgs == 0)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time,
               n_msgs, 1);
    end
    final_report();
  end
endmodule
